// file: rxmon_cfg.svh
// Register indices, field positions and timing counts of the receive monitor
`ifndef RXMON_CFG_SVH
`define RXMON_CFG_SVH

`define RXM_IDX_CTRL       6'h10
`define RXM_IDX_INFO       6'h16
`define RXM_IDX_BPV        6'h20
`define RXM_IDX_EXZ        6'h22
`define RXM_IDX_FE         6'h24
`define RXM_IDX_PAR        6'h26
`define RXM_IDX_CPAR       6'h28
`define RXM_IDX_FEBE       6'h2A

`define RXM_CTRL_E3        0
`define RXM_CTRL_CVSEL     1
`define RXM_CTRL_FCLO      2
`define RXM_CTRL_FCHI      3
`define RXM_CTRL_ECC       4
`define RXM_CTRL_AUTO      5
`define RXM_CTRL_MANUAL    6
`define RXM_CTRL_RESET     8'h20

`define RXM_INFO_SEVERE_FRAMING_EVENT      5
`define RXM_INFO_SN        8
`define RXM_INFO_APPID     9
`define RXM_INFO_SIGNAL_LOSS_CLEARED      10
`define RXM_INFO_FRAME_LOSS_CLEARED      11
`define RXM_INFO_ALARM_SIGNAL_CLEARED      12
`define RXM_INFO_REMOTE_ALARM_CLEARED      13

`define RXM_EXZ_T3         3'h3
`define RXM_EXZ_E3         3'h4
`define RXM_LOS_BITS       8'hC0
`define RXM_SEF_F_WIN      16
`define RXM_SEF_F_ERRS     5'h03
`define RXM_SEF_FAS_RUN    3'h4
`define RXM_APPID_FRAMES   10'h3FF
`define RXM_APPID_ONES     11'h3FC
`define RXM_SECOND_NS      1000000000
`define RXM_CLK_NS         5
`define RXM_SECOND_CYCLES  (`RXM_SECOND_NS / `RXM_CLK_NS)

`endif

// file: rxmon_pkg.sv
// Types shared by the receive monitor files
package rxmon_pkg;

  typedef logic [15:0] count_t;

  typedef enum logic [1:0] {
    FC_LOF,
    FC_FRAME_ALL,
    FC_FRAME_F,
    FC_FRAME_M
  } frame_sel_e;

endpackage : rxmon_pkg

// file: err_counter.sv
// Saturating error accumulator with a host-visible snapshot
`timescale 1ns/1ps
module err_counter #(
  parameter int W = 16
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic         inc_i,
  input  wire logic         update_i,
  output logic     [W-1:0]  count_o
);

  logic [W-1:0] acc_q;
  logic [W-1:0] acc_inc;
  wire          acc_full = &acc_q;

  assign acc_inc = acc_full ? acc_q : acc_q + {{(W-1){1'b0}}, 1'b1};

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_q   <= '0;
      count_o <= '0;
    end else if (update_i) begin
      count_o <= acc_q;
      acc_q   <= {{(W-1){1'b0}}, inc_i};
    end else if (inc_i) begin
      acc_q   <= acc_inc;
    end
  end

  a_snapshot_move: assert property (@(posedge clock_i) disable iff (!nrst_i)
    update_i |=> (count_o == $past(acc_q)) && (acc_q == {{(W-1){1'b0}}, $past(inc_i)}))
    else $error("snapshot did not take accumulation");

  a_sat_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (acc_full && !update_i) |=> acc_full)
    else $error("accumulator wrapped");

endmodule : err_counter

// file: rx_status_monitor.sv
// Receive status flags, alarm-clear events and performance counters
`timescale 1ns/1ps
`include "rxmon_cfg.svh"
module rx_status_monitor #(
  parameter int SECOND_CYCLES = `RXM_SECOND_CYCLES
) (
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  input  wire logic [7:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic                   rx_bit_valid_i,
  input  wire logic                   rx_pos_i,
  input  wire logic                   rx_neg_i,
  input  wire logic                   rx_zsub_i,
  input  wire logic                   fbit_valid_i,
  input  wire logic                   fbit_err_i,
  input  wire logic                   mbit_valid_i,
  input  wire logic                   mbit_err_i,
  input  wire logic                   fas_word_end_i,
  input  wire logic                   lof_i,
  input  wire logic                   ais_i,
  input  wire logic                   rai_i,
  input  wire logic                   sn_valid_i,
  input  wire logic                   sn_bit_i,
  input  wire logic                   cbit1_valid_i,
  input  wire logic                   cbit1_i,
  input  wire logic                   par_err_i,
  input  wire logic                   cpar_err_i,
  input  wire logic                   febe_i,
  input  wire logic                   counter_update_pin_i
);
  import rxmon_pkg::*;

  // Control register and mode decode
  logic [7:0]  ctrl_q;
  logic        manual_pulse_q;
  wire         e3_mode   = ctrl_q[`RXM_CTRL_E3];
  wire         cv_sel    = ctrl_q[`RXM_CTRL_CVSEL];
  wire         ecc       = ctrl_q[`RXM_CTRL_ECC];
  wire         auto_upd  = ctrl_q[`RXM_CTRL_AUTO];
  frame_sel_e  frame_sel;
  assign frame_sel = frame_sel_e'({ctrl_q[`RXM_CTRL_FCHI], ctrl_q[`RXM_CTRL_FCLO]});

  // Bus handshake: one wait cycle, then the answer
  logic [5:0]  idx;
  logic        req;
  logic        accept;
  assign idx    = avs_address_i[7:2];
  assign req    = avs_read_i | avs_write_i;
  assign accept = req & ~avs_waitrequest_o;

  // Counter update pin synchroniser and edge detect
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  wire  pin_rise = pin_s2_q & ~pin_s3_q;

  // One-second tick
  logic [31:0] sec_cnt_q;
  wire         sec_tick = (sec_cnt_q == 32'(SECOND_CYCLES - 1));
  wire         cnt_update = auto_upd ? sec_tick : (manual_pulse_q | pin_rise);

  // Bipolar and code violations
  wire  mark = rx_bit_valid_i & (rx_pos_i | rx_neg_i);
  logic last_pol_q;
  logic have_mark_q;
  logic bpv_pol_q;
  logic have_bpv_q;
  wire  bpv = mark & have_mark_q & (rx_pos_i == last_pol_q) & ~rx_zsub_i;
  wire  cv  = bpv & have_bpv_q & (rx_pos_i == bpv_pol_q);
  wire  bpv_ev = (e3_mode & cv_sel) ? cv : bpv;

  // Excess zeros: a run counts once, when it reaches the threshold
  logic [2:0] zrun_q;
  wire  [2:0] exz_thr = e3_mode ? `RXM_EXZ_E3 : `RXM_EXZ_T3;
  wire        zero_bit = rx_bit_valid_i & ~(rx_pos_i | rx_neg_i);
  wire  [2:0] zrun_inc = (zrun_q == 3'h7) ? zrun_q : zrun_q + 3'h1;
  wire        exz_ev = zero_bit & (zrun_inc == exz_thr) & (zrun_q != exz_thr);

  // Loss of signal
  logic       los_q;
  logic [7:0] zcnt_q;
  logic       win_act_q;
  logic [7:0] win_cnt_q;
  wire        los_enter = ~los_q & zero_bit & (zcnt_q == `RXM_LOS_BITS - 8'h01);
  wire        los_exit  = los_q & win_act_q & rx_bit_valid_i & ~exz_ev
                          & (win_cnt_q == `RXM_LOS_BITS - 8'h01);

  // Severe framing detection
  logic [15:0] fwin_q;
  logic [4:0]  ferr_old;
  logic [4:0]  ferr_new;
  logic [2:0]  fas_run_q;
  logic        fas_acc_q;
  wire  [15:0] fwin_d = {fwin_q[14:0], fbit_err_i};
  wire         fas_word_err = fas_acc_q | (fbit_valid_i & fbit_err_i);
  wire         fas_word_bad = e3_mode & fas_word_end_i & fas_word_err;
  wire  [2:0]  fas_run_inc = (fas_run_q == `RXM_SEF_FAS_RUN) ? fas_run_q : fas_run_q + 3'h1;

  function automatic logic [4:0] popcount16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < `RXM_SEF_F_WIN; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction : popcount16

  assign ferr_old = popcount16(fwin_q);
  assign ferr_new = popcount16(fwin_d);
  wire sef_t3 = ~e3_mode & fbit_valid_i & (ferr_new >= `RXM_SEF_F_ERRS)
                & (ferr_old < `RXM_SEF_F_ERRS);
  wire sef_e3 = fas_word_bad & (fas_run_q == `RXM_SEF_FAS_RUN - 3'h1);

  // Alarm edges
  logic lof_d_q;
  logic ais_d_q;
  logic rai_d_q;
  wire  lof_rise = lof_i & ~lof_d_q;
  wire  lof_fall = ~lof_i & lof_d_q;
  wire  ais_fall = ~ais_i & ais_d_q;
  wire  rai_fall = ~rai_i & rai_d_q;

  // Frame error counter source
  wire  frm_ok = ecc | ~lof_i;
  wire  f_err  = fbit_valid_i & fbit_err_i;
  wire  m_err  = ~e3_mode & mbit_valid_i & mbit_err_i;
  logic fe_ev;
  always_comb begin
    case (frame_sel)
      FC_LOF:       fe_ev = lof_rise;
      FC_FRAME_ALL: fe_ev = frm_ok & (f_err | m_err);
      FC_FRAME_F:   fe_ev = frm_ok & (e3_mode ? (fas_word_end_i & fas_word_err) : f_err);
      FC_FRAME_M:   fe_ev = frm_ok & m_err;
      default:      fe_ev = 1'b0;
    endcase
  end

  // Application ID and national bit
  logic [9:0]  aid_frames_q;
  logic [10:0] aid_ones_q;
  logic        app_id_q;
  logic        national_bit_q;
  wire  [10:0] aid_ones_d = aid_ones_q + {10'h000, cbit1_i};
  wire         aid_block_end = cbit1_valid_i & (aid_frames_q == `RXM_APPID_FRAMES);

  // Latched event flags: severe framing, LOS, LOF, AIS, RAI exits
  logic [4:0] flags_q;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [31:0] rd_mux;
  logic [15:0] info_word;
  assign flag_set = {rai_fall, ais_fall, lof_fall, los_exit, sef_t3 | sef_e3};
  assign flag_clr = (accept & avs_read_i & (idx == `RXM_IDX_INFO)) ?
                    {avs_readdata_o[`RXM_INFO_REMOTE_ALARM_CLEARED], avs_readdata_o[`RXM_INFO_ALARM_SIGNAL_CLEARED],
                     avs_readdata_o[`RXM_INFO_FRAME_LOSS_CLEARED], avs_readdata_o[`RXM_INFO_SIGNAL_LOSS_CLEARED],
                     avs_readdata_o[`RXM_INFO_SEVERE_FRAMING_EVENT]} : 5'h00;
  // Status bits drive no interrupt; the block has no interrupt output

  always_comb begin
    info_word = 16'h0000;
    info_word[`RXM_INFO_SEVERE_FRAMING_EVENT]  = flags_q[0];
    info_word[`RXM_INFO_SN]    = national_bit_q;
    info_word[`RXM_INFO_APPID] = app_id_q;
    info_word[`RXM_INFO_SIGNAL_LOSS_CLEARED]  = flags_q[1];
    info_word[`RXM_INFO_FRAME_LOSS_CLEARED]  = flags_q[2];
    info_word[`RXM_INFO_ALARM_SIGNAL_CLEARED]  = flags_q[3];
    info_word[`RXM_INFO_REMOTE_ALARM_CLEARED]  = flags_q[4];
  end

  // Performance counters
  count_t cnt_bpv;
  count_t cnt_exz;
  count_t cnt_fe;
  count_t cnt_par;
  count_t cnt_cpar;
  count_t cnt_febe;

  err_counter #(.W(16)) u_bpv  (.clock_i(clock_i), .nrst_i(nrst_i), .inc_i(bpv_ev),
                                .update_i(cnt_update), .count_o(cnt_bpv));
  err_counter #(.W(16)) u_exz  (.clock_i(clock_i), .nrst_i(nrst_i), .inc_i(exz_ev),
                                .update_i(cnt_update), .count_o(cnt_exz));
  err_counter #(.W(16)) u_fe   (.clock_i(clock_i), .nrst_i(nrst_i), .inc_i(fe_ev),
                                .update_i(cnt_update), .count_o(cnt_fe));
  err_counter #(.W(16)) u_par  (.clock_i(clock_i), .nrst_i(nrst_i), .inc_i(par_err_i & frm_ok),
                                .update_i(cnt_update), .count_o(cnt_par));
  err_counter #(.W(16)) u_cpar (.clock_i(clock_i), .nrst_i(nrst_i), .inc_i(cpar_err_i & frm_ok),
                                .update_i(cnt_update), .count_o(cnt_cpar));
  err_counter #(.W(16)) u_febe (.clock_i(clock_i), .nrst_i(nrst_i), .inc_i(febe_i & frm_ok),
                                .update_i(cnt_update), .count_o(cnt_febe));

  // Read data selection; unmapped indices read zero
  always_comb begin
    if (idx == `RXM_IDX_CTRL) begin
      rd_mux = {24'h000000, ctrl_q & ~(8'h01 << `RXM_CTRL_MANUAL)};
    end else if (idx == `RXM_IDX_INFO) begin
      rd_mux = {16'h0000, info_word};
    end else if (idx == `RXM_IDX_BPV) begin
      rd_mux = {16'h0000, cnt_bpv};
    end else if (idx == `RXM_IDX_EXZ) begin
      rd_mux = {16'h0000, cnt_exz};
    end else if (idx == `RXM_IDX_FE) begin
      rd_mux = {16'h0000, cnt_fe};
    end else if (idx == `RXM_IDX_PAR) begin
      rd_mux = {16'h0000, cnt_par};
    end else if (idx == `RXM_IDX_CPAR) begin
      rd_mux = {16'h0000, cnt_cpar};
    end else if (idx == `RXM_IDX_FEBE) begin
      rd_mux = {16'h0000, cnt_febe};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  wire ctrl_wr = accept & avs_write_i & (idx == `RXM_IDX_CTRL) & avs_byteenable_i[0];

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
      ctrl_q            <= `RXM_CTRL_RESET;
      manual_pulse_q    <= 1'b0;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (req & avs_waitrequest_o) begin
        avs_readdata_o <= avs_read_i ? rd_mux : 32'h00000000;
      end
      manual_pulse_q <= ctrl_wr & avs_writedata_i[`RXM_CTRL_MANUAL];
      if (ctrl_wr) begin
        ctrl_q <= avs_writedata_i[7:0] & ~(8'h01 << `RXM_CTRL_MANUAL);
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q  <= 1'b0;
      pin_s2_q  <= 1'b0;
      pin_s3_q  <= 1'b0;
      sec_cnt_q <= 32'h00000000;
      flags_q   <= 5'h00;
      lof_d_q   <= 1'b0;
      ais_d_q   <= 1'b0;
      rai_d_q   <= 1'b0;
    end else begin
      pin_s1_q  <= counter_update_pin_i;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      sec_cnt_q <= sec_tick ? 32'h00000000 : sec_cnt_q + 32'h00000001;
      flags_q   <= flag_set | (flags_q & ~flag_clr);
      lof_d_q   <= lof_i;
      ais_d_q   <= ais_i;
      rai_d_q   <= rai_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_pol_q  <= 1'b0;
      have_mark_q <= 1'b0;
      bpv_pol_q   <= 1'b0;
      have_bpv_q  <= 1'b0;
      zrun_q      <= 3'h0;
    end else if (rx_bit_valid_i) begin
      if (mark) begin
        last_pol_q  <= rx_pos_i;
        have_mark_q <= 1'b1;
        zrun_q      <= 3'h0;
      end else begin
        zrun_q      <= zrun_inc;
      end
      if (bpv) begin
        bpv_pol_q  <= rx_pos_i;
        have_bpv_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      los_q     <= 1'b0;
      zcnt_q    <= 8'h00;
      win_act_q <= 1'b0;
      win_cnt_q <= 8'h00;
    end else if (rx_bit_valid_i) begin
      zcnt_q <= mark ? 8'h00 : ((zcnt_q == `RXM_LOS_BITS) ? zcnt_q : zcnt_q + 8'h01);
      if (los_enter) begin
        los_q     <= 1'b1;
        win_act_q <= 1'b0;
      end else if (los_exit) begin
        los_q     <= 1'b0;
        win_act_q <= 1'b0;
      end else if (los_q & win_act_q & exz_ev) begin
        win_act_q <= 1'b0;
      end else if (los_q & win_act_q) begin
        win_cnt_q <= win_cnt_q + 8'h01;
      end else if (los_q & mark) begin
        win_act_q <= 1'b1;
        win_cnt_q <= 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwin_q    <= 16'h0000;
      fas_run_q <= 3'h0;
      fas_acc_q <= 1'b0;
    end else begin
      if (fbit_valid_i & ~e3_mode) begin
        fwin_q <= fwin_d;
      end
      if (e3_mode & fas_word_end_i) begin
        fas_run_q <= fas_word_err ? fas_run_inc : 3'h0;
        fas_acc_q <= 1'b0;
      end else if (fbit_valid_i & fbit_err_i) begin
        fas_acc_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aid_frames_q   <= 10'h000;
      aid_ones_q     <= 11'h000;
      app_id_q       <= 1'b0;
      national_bit_q <= 1'b0;
    end else begin
      if (sn_valid_i) begin
        national_bit_q <= sn_bit_i;
      end
      if (aid_block_end) begin
        app_id_q     <= (aid_ones_d >= `RXM_APPID_ONES);
        aid_frames_q <= 10'h000;
        aid_ones_q   <= 11'h000;
      end else if (cbit1_valid_i) begin
        aid_frames_q <= aid_frames_q + 10'h001;
        aid_ones_q   <= aid_ones_d;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_read_info;
    accept && avs_read_i && (idx == `RXM_IDX_INFO);
  endsequence

  a_wait_one_cycle: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  a_flag_clear: assert property (s_read_info ##0 (avs_readdata_o[`RXM_INFO_SIGNAL_LOSS_CLEARED]
    && !los_exit) |=> !flags_q[1])
    else $error("loss-of-signal clear flag not cleared by read");
  a_set_wins: assert property (lof_fall |=> flags_q[2])
    else $error("frame loss clear event lost");
  a_alarm_exit: assert property ($fell(ais_i) ##1 1'b1 |-> flags_q[3])
    else $error("alarm signal exit not flagged");
  a_remote_exit: assert property (rai_fall |=> flags_q[4])
    else $error("remote alarm exit not flagged");
  a_sef_set: assert property ((sef_t3 || sef_e3) |=> flags_q[0])
    else $error("severe framing event not flagged");
  a_los_enter: assert property (los_enter |=> los_q)
    else $error("signal loss not entered after run of zeros");
  a_exz_once: assert property (exz_ev |=> !exz_ev)
    else $error("excess zero counted twice in one run");
  a_appid_set: assert property (aid_block_end && (aid_ones_d >= 11'h3FC) |=> app_id_q)
    else $error("application id not set");
  a_appid_clr: assert property (aid_block_end && (aid_ones_d < 11'h3FC) |=> !app_id_q)
    else $error("application id not cleared");
  a_national: assert property (sn_valid_i |=> national_bit_q == $past(sn_bit_i))
    else $error("national bit not loaded");
  a_lof_count: assert property (frame_sel == FC_LOF && lof_rise |=> u_fe.acc_q != '0)
    else $error("frame loss not counted");

endmodule : rx_status_monitor

// file: line_src.sv
// Line interface model that hands received bipolar bits to the monitor
`timescale 1ns/1ps
module line_src (
  input  wire logic clock_i,
  output logic      rx_bit_valid_o,
  output logic      rx_pos_o,
  output logic      rx_neg_o,
  output logic      rx_zsub_o
);
  logic last_pos;

  initial begin
    rx_bit_valid_o = 1'b0;
    rx_pos_o       = 1'b0;
    rx_neg_o       = 1'b0;
    rx_zsub_o      = 1'b0;
    last_pos       = 1'b0;
  end

  // One bit per call; a mark alternates polarity unless it is meant to violate
  task automatic send(input logic mark, input logic viol, input logic zsub);
    logic pol;
    pol = viol ? last_pos : ~last_pos;
    @(posedge clock_i);
    rx_bit_valid_o <= 1'b1;
    rx_pos_o       <= mark & pol;
    rx_neg_o       <= mark & ~pol;
    rx_zsub_o      <= zsub;
    if (mark) last_pos = pol;
  endtask : send

  // A released line shows the inverse of the last bit, never a stale copy
  task automatic idle();
    @(posedge clock_i);
    rx_bit_valid_o <= 1'b0;
    rx_pos_o       <= ~rx_pos_o;
    rx_neg_o       <= ~rx_neg_o;
    rx_zsub_o      <= ~rx_zsub_o;
  endtask : idle
endmodule : line_src

// file: rx_status_monitor_tb.sv
// Self-checking bench for the receive status monitor
`timescale 1ns/1ps
module rx_status_monitor_tb;
  typedef struct {
    logic [31:0] v;
    logic [31:0] m;
    string       n;
  } note_s;

  localparam logic [31:0] ALL   = 32'hFFFFFFFF;
  localparam int          LIMIT = 90000;

  logic        clock_i = 1'b0;
  logic        nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0]  avs_address_i, ctrl;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [9:0]  ev;
  logic [2:0]  al;
  logic        par_lvl, sn_bit_i, cbit1_i, counter_update_pin_i;
  logic        rx_bit_valid_i, rx_pos_i, rx_neg_i, rx_zsub_i;
  logic        fbit_valid_i, fbit_err_i, mbit_valid_i, mbit_err_i, fas_word_end_i;
  logic        lof_i, ais_i, rai_i, sn_valid_i, cbit1_valid_i, par_err_i, cpar_err_i, febe_i;
  note_s       exp_q[$];
  note_s       e;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  integer      seed = 71;
  int          nf, nm;

  always #2.5 clock_i = ~clock_i;

  assign {cbit1_valid_i, sn_valid_i, febe_i, cpar_err_i, par_err_i, fas_word_end_i,
          mbit_err_i, mbit_valid_i, fbit_err_i, fbit_valid_i} = ev | {4'h0, par_lvl, 5'h00};
  assign {rai_i, ais_i, lof_i} = al;

  line_src src (.clock_i, .rx_bit_valid_o(rx_bit_valid_i), .rx_pos_o(rx_pos_i),
                .rx_neg_o(rx_neg_i), .rx_zsub_o(rx_zsub_i));

  rx_status_monitor #(.SECOND_CYCLES(50)) uut (
    .clock_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .rx_bit_valid_i,
    .rx_pos_i, .rx_neg_i, .rx_zsub_i, .fbit_valid_i, .fbit_err_i, .mbit_valid_i,
    .mbit_err_i, .fas_word_end_i, .lof_i, .ais_i, .rai_i, .sn_valid_i, .sn_bit_i,
    .cbit1_valid_i, .cbit1_i, .par_err_i, .cpar_err_i, .febe_i, .counter_update_pin_i);

  task automatic stop_test();
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Avalon-MM transfer: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_read_i      <= ~wr;
    avs_write_i     <= wr;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      stop_test();
    end
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
                    input string n);
    exp_q.push_back('{v, m, n});
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic setc(input logic [7:0] c);
    logic [31:0] r;
    r = $random(seed);
    ctrl = c;
    bus(1'b1, 8'h40, {r[31:8], c});
  endtask : setc

  // Manual update; the snapshot lands a few edges after the write
  task automatic upd();
    bus(1'b1, 8'h40, {24'h0, ctrl | 8'h40});
    repeat (4) @(posedge clock_i);
  endtask : upd

  task automatic pulse(input logic [9:0] mask, input int n);
    repeat (n) begin
      @(posedge clock_i);
      ev <= mask;
      @(posedge clock_i);
      ev <= 10'h000;
    end
  endtask : pulse

  task automatic zrun(input int n);
    repeat (n) src.send(1'b0, 1'b0, 1'b0);
    src.send(1'b1, 1'b0, 1'b0);
  endtask : zrun

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      stop_test();
    end else if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      checked++;
      if ((avs_readdata_o & e.m) !== (e.v & e.m)) begin
        $display("[FAIL] %s expected %h seen %h", e.n, e.v & e.m, avs_readdata_o & e.m);
        err_count++;
      end
    end
  end

  initial begin
    {nrst_i, avs_read_i, avs_write_i, ev, al, par_lvl, sn_bit_i, cbit1_i} = '0;
    {counter_update_pin_i, avs_address_i, avs_writedata_i, ctrl} = '0;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    rd(8'h40, 32'h20, ALL, "ctrl reset");
    rd(8'h44, 32'h0, ALL, "unmapped");
    par_lvl <= 1'b1;
    repeat (120) @(posedge clock_i);
    rd(8'h98, 32'h32, ALL, "auto parity");
    setc(8'h00);
    repeat (65600) @(posedge clock_i);
    par_lvl <= 1'b0;
    upd();
    rd(8'h98, 32'hFFFF, ALL, "parity saturated");
    pulse(10'h0E0, 2);
    pulse(10'h080, 1);
    counter_update_pin_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    counter_update_pin_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rd(8'h98, 32'h2, ALL, "parity pin");
    rd(8'hA0, 32'h2, ALL, "cparity pin");
    rd(8'hA8, 32'h3, ALL, "febe pin");
    // T3, E3, then E3 with code violation counting
    for (int m = 0; m < 3; m++) begin
      setc(m == 2 ? 8'h03 : 8'(m));
      upd();
      src.send(1'b1, 1'b0, 1'b0);
      src.send(1'b1, 1'b1, 1'b0);
      src.send(1'b1, 1'b1, 1'b1);
      src.send(1'b1, 1'b0, 1'b0);
      src.send(1'b1, 1'b1, 1'b0);
      zrun(m == 0 ? 2 : 3);
      zrun(m == 0 ? 3 : 4);
      zrun(8);
      src.idle();
      upd();
      // Two opposite violations per pass; the first of the second and third passes repeats a polarity, counted in the third only
      rd(8'h80, m == 2 ? 32'h1 : 32'h2, ALL, "bpv");
      rd(8'h88, 32'h2, ALL, "exz");
    end
    setc(8'h00);
    upd();
    for (int i = 0; i < 3; i++) begin
      al <= 3'(1 << i);
      repeat (4) @(posedge clock_i);
      al <= 3'b000;
      repeat (4) @(posedge clock_i);
    end
    upd();
    rd(8'h90, 32'h1, ALL, "fe lof");
    rd(8'h58, 32'h3800, 32'h3800, "alarm clears");
    rd(8'h58, 32'h0, 32'h3800, "alarm clears read");
    for (int fc = 1; fc < 4; fc++) begin
      setc(8'(fc << 2));
      upd();
      nf = ($random(seed) & 3) + 1;
      nm = ($random(seed) & 3) + 1;
      pulse(10'h003, nf);
      pulse(10'h00C, nm);
      upd();
      rd(8'h90, 32'(fc == 1 ? nf + nm : fc == 2 ? nf : nm), ALL, "fe select");
    end
    for (int k = 0; k < 2; k++) begin
      setc(8'(8'h08 | (k << 4)));
      upd();
      al <= 3'b001;
      repeat (2) @(posedge clock_i);
      pulse(10'h003, 2);
      al <= 3'b000;
      upd();
      rd(8'h90, 32'(2 * k), ALL, "fe during lof");
    end
    pulse(10'h001, 16);
    rd(8'h58, 32'h800, 32'h800, "lof clear");
    pulse(10'h003, 3);
    rd(8'h58, 32'h20, 32'h20, "severe framing");
    rd(8'h58, 32'h0, 32'h20, "severe framing read");
    setc(8'h09);
    upd();
    pulse(10'h013, 4);
    upd();
    rd(8'h90, 32'h4, ALL, "fe fas words");
    rd(8'h58, 32'h20, 32'h20, "severe framing e3");
    for (int v = 1; v >= 0; v--) begin
      sn_bit_i <= v[0];
      pulse(10'h100, 1);
      rd(8'h58, 32'(v << 8), 32'h100, "national bit");
    end
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 1024; i++) begin
        cbit1_i <= (i >= 4 + b);
        pulse(10'h200, 1);
      end
      rd(8'h58, b ? 32'h0 : 32'h200, 32'h200, "app id");
    end
    rd(8'h58, 32'h0, 32'h3C20, "flags idle");
    repeat (192) src.send(1'b0, 1'b0, 1'b0);
    repeat (200) src.send(1'b1, 1'b0, 1'b0);
    src.idle();
    rd(8'h58, 32'h400, 32'h400, "los clear");
    rd(8'h58, 32'h0, 32'h400, "los clear read");
    stop_test();
  end
endmodule : rx_status_monitor_tb
